// >>> core/sar_adc_control_readout.sv
// Chosen here: register access over APB.
`timescale 1ns/1ps
// Function
// - Set completion flag when conversion finishes
// - Interrupt only when irq enable set
// - Result held until next conversion ends
// - High result read clears completion flag
// - Channel write restarts conversion on new channel
// - Low result read locks both results
// - High read or disable releases lock
// - No result update while lock held
// - Wait mode unaffected; irq wakes from wait
// - Halt disables converter; software waits settle
// - Divider field picks 4, 2, 1 MHz
// - Enable bit starts or stops conversion
// - Channel field binary selects input 0-15
// - High register holds result bits 9:2
// - Low register holds bits 1:0, rest zero
// - Control register writable except flag bit
// - Converts continuously while enabled
// - Flag stays set through later conversions until high read
// - Stretch bit lengthens sampling phase
module sar_adc_control_readout
   import sar_adc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic cmp_hi_i,
   output logic [3:0] chan_sel_o,
   output logic sample_o,
   output logic [RESULT_W-1:0] trial_o,
   output logic analog_on_o,
   output logic irq_o,
   output logic wake_o
);
   // ***************************
   // Register state
   // ***************************
   logic [1:0] conv_clock_divider_ff;
   logic converter_enable_ff;
   logic [3:0] chan_ff;
   logic done_flag_ff;
   logic conversion_irq_enable_ff;
   logic sample_time_stretch_ff;
   logic wait_mode_ff;
   logic halt_mode_ff;
   logic lock_ff;
   logic [RESULT_W-1:0] result_ff;
   logic [31:0] nxt_rdata;
   logic nxt_err;
   logic access;
   logic wr;
   logic rd;
   logic idx_ok;
   logic [7:0] idx;
   logic run;
   logic restart;
   logic tick;
   logic eng_done;
   logic eng_sample;
   logic [RESULT_W-1:0] eng_trial;
   logic [RESULT_W-1:0] eng_result;
   logic wr_csr;
   logic wr_mcfg;
   logic wr_pmode;
   logic rd_high;
   logic rd_low;
   logic [2:0] cmp_sync_ff;
   logic cmp_hi_ff;

   function automatic logic hit(input logic [7:0] a, input logic [7:0] target);
      hit = (a == target);
   endfunction : hit

   // ***************************
   // APB decode
   // ***************************
   assign access = psel_i && penable_i && pready_o;
   assign idx = paddr_i[ADDR_W-1:2];
   assign idx_ok = (paddr_i[1:0] == 2'h0);
   assign wr = access && pwrite_i && idx_ok;
   assign rd = access && !pwrite_i && idx_ok;
   // Halt powers the converter down
   assign run = converter_enable_ff && !halt_mode_ff;
   assign restart = wr_csr && (pwdata_i[CSR_CHAN_HI:0] != chan_ff);

   // ***************************
   // Register strobes
   // ***************************
   assign wr_csr = wr && hit(idx, IDX_CTRL_STATUS);
   assign wr_mcfg = wr && hit(idx, IDX_MOTOR_CFG);
   assign wr_pmode = wr && hit(idx, IDX_POWER_MODE);
   assign rd_high = rd && hit(idx, IDX_RESULT_HIGH);
   assign rd_low = rd && hit(idx, IDX_RESULT_LOW);

   // One wait state: answer in the access phase's second edge
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         pready_o <= 1'b0;
      end else begin
         pready_o <= psel_i && penable_i && !pready_o;
      end
   end

   always_comb begin
      nxt_rdata = 32'h0000_0000;
      nxt_err = 1'b0;
      if (!idx_ok) begin
         nxt_err = 1'b1;
      end else if (hit(idx, IDX_CTRL_STATUS)) begin
         nxt_rdata[7:0] = {done_flag_ff, conv_clock_divider_ff, converter_enable_ff, chan_ff};
      end else if (hit(idx, IDX_RESULT_HIGH)) begin
         nxt_rdata[7:0] = result_ff[RESULT_W-1:2];
      end else if (hit(idx, IDX_RESULT_LOW)) begin
         nxt_rdata[1:0] = result_ff[1:0];
      end else if (hit(idx, IDX_MOTOR_CFG)) begin
         nxt_rdata[MCFG_IRQ_EN_BIT] = conversion_irq_enable_ff;
         nxt_rdata[MCFG_STRETCH_BIT] = sample_time_stretch_ff;
      end else if (hit(idx, IDX_POWER_MODE)) begin
         nxt_rdata[PMODE_WAIT_BIT] = wait_mode_ff;
         nxt_rdata[PMODE_HALT_BIT] = halt_mode_ff;
      end else begin
         nxt_err = 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         prdata_o <= 32'h0000_0000;
         pslverr_o <= 1'b0;
      end else if (psel_i && penable_i && !pready_o) begin
         prdata_o <= pwrite_i ? 32'h0000_0000 : nxt_rdata;
         pslverr_o <= nxt_err;
      end else begin
         pslverr_o <= 1'b0;
      end
   end

   // ***************************
   // Writable fields
   // ***************************
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         {conv_clock_divider_ff, converter_enable_ff, chan_ff} <= RESET_BYTE[6:0];
      end else if (wr_csr) begin
         // Top bit ignored: flag is read-only
         conv_clock_divider_ff <= pwdata_i[CSR_DIV_HI:CSR_DIV_LO];
         converter_enable_ff <= pwdata_i[CSR_ENABLE_BIT];
         chan_ff <= pwdata_i[CSR_CHAN_HI:0];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         conversion_irq_enable_ff <= 1'b0;
         sample_time_stretch_ff <= 1'b0;
      end else if (wr_mcfg) begin
         conversion_irq_enable_ff <= pwdata_i[MCFG_IRQ_EN_BIT];
         sample_time_stretch_ff <= pwdata_i[MCFG_STRETCH_BIT];
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         wait_mode_ff <= 1'b0;
         halt_mode_ff <= 1'b0;
      end else if (wr_pmode) begin
         wait_mode_ff <= pwdata_i[PMODE_WAIT_BIT];
         halt_mode_ff <= pwdata_i[PMODE_HALT_BIT];
      end
   end

   // ***************************
   // Converter
   // ***************************
   conv_tick_gen u_tick (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .run_i(run),
      .div_sel_i(conv_clock_divider_ff),
      .tick_o(tick)
   );

   // ***************************
   // Comparator input
   // ***************************
   // Comparator output is asynchronous; latency is far below one tick
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         cmp_sync_ff <= 3'h0;
      end else begin
         cmp_sync_ff <= {cmp_sync_ff[1:0], cmp_hi_i};
      end
   end

   // A change counts only once the last two stages agree
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         cmp_hi_ff <= 1'b0;
      end else if (cmp_sync_ff[1] == cmp_sync_ff[2]) begin
         cmp_hi_ff <= cmp_sync_ff[2];
      end
   end

   sar_engine u_engine (
      .mclk_i(mclk_i),
      .reset_i(reset_i),
      .run_i(run),
      .restart_i(restart),
      .tick_i(tick),
      .stretch_i(sample_time_stretch_ff),
      .cmp_hi_i(cmp_hi_ff),
      .sample_o(eng_sample),
      .trial_o(eng_trial),
      .done_o(eng_done),
      .result_o(eng_result)
   );

   // ***************************
   // Flag, lock, results
   // ***************************
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         done_flag_ff <= 1'b0;
      end else if (eng_done) begin
         done_flag_ff <= 1'b1;
      end else if (rd_high) begin
         done_flag_ff <= 1'b0;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i || !converter_enable_ff) begin
         lock_ff <= 1'b0;
      end else if (rd_high) begin
         lock_ff <= 1'b0;
      end else if (rd_low) begin
         lock_ff <= 1'b1;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         result_ff <= 10'h000;
      end else if (eng_done && !lock_ff) begin
         result_ff <= eng_result;
      end
   end

   // ***************************
   // Pins
   // ***************************
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         chan_sel_o <= 4'h0;
         sample_o <= 1'b0;
         trial_o <= 10'h000;
      end else begin
         chan_sel_o <= chan_ff;
         sample_o <= eng_sample;
         trial_o <= eng_trial;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         analog_on_o <= 1'b0;
      end else begin
         analog_on_o <= run;
      end
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         irq_o <= 1'b0;
         wake_o <= 1'b0;
      end else begin
         irq_o <= done_flag_ff && conversion_irq_enable_ff;
         // Wake only from wait; halt stops the converter anyway
         wake_o <= done_flag_ff && conversion_irq_enable_ff
                   && wait_mode_ff && !halt_mode_ff;
      end
   end
endmodule : sar_adc_control_readout

// >>> core/sar_adc_pkg.sv
package sar_adc_pkg;
   // ***************************
   // Register map
   // ***************************
   // Printed offsets are not all multiples of four: they are indices
   localparam logic [7:0] IDX_CTRL_STATUS = 8'h2e;
   localparam logic [7:0] IDX_RESULT_HIGH = 8'h2f;
   localparam logic [7:0] IDX_RESULT_LOW = 8'h30;
   localparam logic [7:0] IDX_MOTOR_CFG = 8'h31;
   localparam logic [7:0] IDX_POWER_MODE = 8'h32;
   localparam int ADDR_W = 10;

   // ***************************
   // Fields
   // ***************************
   localparam int CSR_DONE_BIT = 7;
   localparam int CSR_DIV_HI = 6;
   localparam int CSR_DIV_LO = 5;
   localparam int CSR_ENABLE_BIT = 4;
   localparam int CSR_CHAN_HI = 3;
   localparam int MCFG_IRQ_EN_BIT = 0;
   localparam int MCFG_STRETCH_BIT = 1;
   localparam int PMODE_WAIT_BIT = 0;
   localparam int PMODE_HALT_BIT = 1;
   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam int RESULT_W = 10;

   // ***************************
   // Timing
   // ***************************
   localparam int CLK_MHZ = 100;
   localparam int FADC_4_MHZ = 4;
   localparam int FADC_2_MHZ = 2;
   localparam int FADC_1_MHZ = 1;
   // Highest allowed rate rounds the divider up
   localparam logic [7:0] DIV_CODE0 = 8'((CLK_MHZ + FADC_4_MHZ - 1) / FADC_4_MHZ);
   localparam logic [7:0] DIV_CODE1 = 8'((CLK_MHZ + FADC_2_MHZ - 1) / FADC_2_MHZ);
   localparam logic [7:0] DIV_CODE2 = 8'((CLK_MHZ + FADC_1_MHZ - 1) / FADC_1_MHZ);
   localparam logic [1:0] DIV_SEL_4MHZ = 2'h0;
   localparam logic [1:0] DIV_SEL_2MHZ = 2'h1;
   localparam logic [1:0] DIV_SEL_1MHZ = 2'h2;
   localparam logic [4:0] SAMPLE_TICKS = 5'h03;
   localparam logic [4:0] SAMPLE_TICKS_LONG = 5'h0c;
   localparam logic [3:0] BITS_LAST = 4'h9;

   typedef enum logic [1:0] {
      CONV_IDLE = 2'b00,
      CONV_SAMPLE = 2'b01,
      CONV_APPROX = 2'b10
   } conv_state_t;
endpackage : sar_adc_pkg

// >>> core/conv_tick_gen.sv
`timescale 1ns/1ps
// Converter clock enable from the peripheral clock
module conv_tick_gen
   import sar_adc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic run_i,
   input wire logic [1:0] div_sel_i,
   output logic tick_o
);
   logic [7:0] cnt_ff;
   logic [7:0] div_val;

   always_comb begin
      case (div_sel_i)
         DIV_SEL_4MHZ: div_val = DIV_CODE0;
         DIV_SEL_2MHZ: div_val = DIV_CODE1;
         DIV_SEL_1MHZ: div_val = DIV_CODE2;
         // Code 11 unlisted: slowest rate
         default: div_val = DIV_CODE2;
      endcase
   end

   always_ff @(posedge mclk_i) begin
      if (reset_i || !run_i) begin
         cnt_ff <= 8'h00;
         tick_o <= 1'b0;
      end else if (cnt_ff >= div_val - 8'h01) begin
         cnt_ff <= 8'h00;
         tick_o <= 1'b1;
      end else begin
         cnt_ff <= cnt_ff + 8'h01;
         tick_o <= 1'b0;
      end
   end
endmodule : conv_tick_gen

// >>> core/sar_engine.sv
`timescale 1ns/1ps
// Successive approximation sequencer facing the comparator
module sar_engine
   import sar_adc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic run_i,
   input wire logic restart_i,
   input wire logic tick_i,
   input wire logic stretch_i,
   input wire logic cmp_hi_i,
   output logic sample_o,
   output logic [RESULT_W-1:0] trial_o,
   output logic done_o,
   output logic [RESULT_W-1:0] result_o
);
   conv_state_t state_ff;
   logic [4:0] cnt_ff;
   logic [3:0] bit_ff;
   logic [RESULT_W-1:0] sar_ff;
   logic [RESULT_W-1:0] probe;

   always_comb begin
      probe = sar_ff | (10'h200 >> bit_ff);
   end

   assign trial_o = probe;
   assign sample_o = (state_ff == CONV_SAMPLE);

   always_ff @(posedge mclk_i) begin
      done_o <= 1'b0;
      if (reset_i || !run_i) begin
         state_ff <= CONV_IDLE;
         cnt_ff <= 5'h00;
         bit_ff <= 4'h0;
         sar_ff <= 10'h000;
         result_o <= 10'h000;
      end else if (restart_i) begin
         state_ff <= CONV_SAMPLE;
         cnt_ff <= 5'h00;
      end else if (tick_i) begin
         case (state_ff)
            CONV_IDLE: begin
               state_ff <= CONV_SAMPLE;
               cnt_ff <= 5'h00;
            end
            CONV_SAMPLE: begin
               // Stretch gives high-impedance sources time to settle
               if (cnt_ff >= (stretch_i ? SAMPLE_TICKS_LONG : SAMPLE_TICKS) - 5'h01) begin
                  state_ff <= CONV_APPROX;
                  bit_ff <= 4'h0;
                  sar_ff <= 10'h000;
               end else begin
                  cnt_ff <= cnt_ff + 5'h01;
               end
            end
            CONV_APPROX: begin
               if (bit_ff == BITS_LAST) begin
                  result_o <= cmp_hi_i ? probe : sar_ff;
                  done_o <= 1'b1;
                  state_ff <= CONV_SAMPLE;
                  cnt_ff <= 5'h00;
               end else begin
                  sar_ff <= cmp_hi_i ? probe : sar_ff;
                  bit_ff <= bit_ff + 4'h1;
               end
            end
            default: state_ff <= CONV_IDLE;
         endcase
      end
   end
endmodule : sar_engine

// >>> testbench/sar_adc_props.sv
`timescale 1ns/1ps
module sar_adc_props
   import sar_adc_pkg::*;
(
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic [3:0] chan_sel_o,
   input wire logic sample_o,
   input wire logic analog_on_o,
   input wire logic irq_o,
   input wire logic wake_o
);
   logic wr;
   logic wcs;
   logic en_ff;
   logic ien_ff;
   logic halt_ff;
   logic [3:0] chan_ff;
   assign wr = psel_i && penable_i && pready_o && pwrite_i && !pslverr_o;
   assign wcs = wr && paddr_i[9:2] == IDX_CTRL_STATUS;
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         en_ff <= 1'b0;
         chan_ff <= 4'h0;
      end else if (wcs) begin
         en_ff <= pwdata_i[CSR_ENABLE_BIT];
         chan_ff <= pwdata_i[3:0];
      end
   end
   always_ff @(posedge mclk_i) begin
      if (reset_i) begin
         ien_ff <= 1'b0;
         halt_ff <= 1'b0;
      end else if (wr && paddr_i[9:2] == IDX_MOTOR_CFG) begin
         ien_ff <= pwdata_i[MCFG_IRQ_EN_BIT];
      end else if (wr && paddr_i[9:2] == IDX_POWER_MODE) begin
         halt_ff <= pwdata_i[PMODE_HALT_BIT];
      end
   end
   // ****
   // Properties
   // ****
   default clocking cb @(posedge mclk_i); endclocking
   default disable iff (reset_i);
   a_ready_pulse: assert property (pready_o |=> !pready_o) else $error("pready held");
   a_low_zeros: assert property (
      pready_o && !pwrite_i && paddr_i[9:2] == IDX_RESULT_LOW |-> prdata_o[31:2] == 30'h0)
      else $error("low result upper bits set");
   a_chan_follows: assert property (wcs ##2 1'b1 |-> chan_sel_o == chan_ff)
      else $error("channel not applied");
   a_irq_gated: assert property (irq_o |-> ien_ff || $past(ien_ff) || $past(ien_ff, 2))
      else $error("irq while masked");
   a_wake_irq: assert property (wake_o |-> irq_o || $past(irq_o)) else $error("wake no irq");
   a_halt_off: assert property (halt_ff [*3] |-> !analog_on_o) else $error("on in halt");
   a_en_off: assert property (!en_ff [*3] |-> !analog_on_o && !sample_o)
      else $error("active while disabled");
   a_sample_min: assert property (
      disable iff (reset_i || !en_ff || halt_ff) $rose(sample_o) |-> sample_o [*8])
      else $error("sample too short");
   a_chan_restart: assert property (
      wcs && en_ff && pwdata_i[4] && !sample_o && analog_on_o
      && pwdata_i[3:0] != chan_ff |-> ##[1:300] sample_o) else $error("no restart");
   c_irq: cover property (irq_o);
   c_wake: cover property (wake_o);
   c_err: cover property (pslverr_o);
endmodule : sar_adc_props
bind sar_adc_control_readout sar_adc_props u_props (.*);

// >>> testbench/sar_adc_partner.sv
`timescale 1ns/1ps
module sar_adc_partner (
   input wire logic mclk_i,
   input wire logic reset_i,
   input wire logic on_i,
   input wire logic [3:0] chan_i,
   input wire logic [9:0] trial_i,
   input wire logic [15:0][9:0] level_i,
   output logic cmp_hi_o
);
   logic junk_ff;
   // Unpowered comparator gives noise, never a held level
   always_ff @(posedge mclk_i) begin
      junk_ff <= reset_i ? 1'b0 : ~junk_ff;
   end
   assign cmp_hi_o = on_i ? (level_i[chan_i] >= trial_i) : junk_ff;
endmodule : sar_adc_partner

// >>> testbench/tb.sv
`timescale 1ns/1ps
module tb
   import sar_adc_pkg::*;
;
   logic mclk_i, reset_i, psel, penable, pwrite, pready, pslverr, cmp, smp, aon, irq, wake, st;
   logic err;
   logic [9:0] paddr, trial, old;
   logic [31:0] pwdata, prdata, rd;
   logic [3:0] chs, ch;
   logic [15:0][9:0] lvl;
   logic [1:0] dv;
   int failures = 0, checks_done = 0, seed = 32'ha8986452, len;
   always #5 mclk_i = ~mclk_i;
   sar_adc_control_readout dut (.mclk_i(mclk_i), .reset_i(reset_i), .psel_i(psel),
      .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
      .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .cmp_hi_i(cmp),
      .chan_sel_o(chs), .sample_o(smp), .trial_o(trial), .analog_on_o(aon), .irq_o(irq),
      .wake_o(wake));
   sar_adc_partner model (.mclk_i(mclk_i), .reset_i(reset_i), .on_i(aon), .chan_i(chs),
      .trial_i(trial), .level_i(lvl), .cmp_hi_o(cmp));
   // ****
   // Helpers
   // ****
   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      checks_done++;
      if (seen !== exp) begin
         failures++;
         $display("unexpected %s: expected %h seen %h", nm, exp, seen);
      end
   endtask : chk
   task automatic report_and_stop();
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0) begin
         $display("All checks passed");
      end else begin
         $display("Checks failed");
      end
      $finish;
   endtask : report_and_stop
   task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] d);
      int n;
      @(posedge mclk_i);
      psel <= 1'b1;
      pwrite <= w;
      paddr <= {idx, 2'b00};
      pwdata <= {24'h0, d};
      @(posedge mclk_i);
      penable <= 1'b1;
      n = 0;
      // Values read right after the edge are those sampled at it
      do begin
         @(posedge mclk_i);
         n++;
      end while (pready !== 1'b1 && n < 20);
      if (pready !== 1'b1) begin
         failures++;
         report_and_stop();
      end
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_flag();
      int n;
      for (n = 0; n < 3000; n++) begin
         apb(1'b0, IDX_CTRL_STATUS, 8'h00);
         if (rd[CSR_DONE_BIT] === 1'b1) break;
      end
      if (n == 3000) begin
         failures++;
         report_and_stop();
      end
   endtask : wait_flag
   function automatic int per(input logic [1:0] d);
      return d == DIV_SEL_4MHZ ? int'(DIV_CODE0) : d == DIV_SEL_2MHZ ? int'(DIV_CODE1) :
         int'(DIV_CODE2);
   endfunction : per
   function automatic int nsamp(input logic s);
      return s ? int'(SAMPLE_TICKS_LONG) : int'(SAMPLE_TICKS);
   endfunction : nsamp
   // ****
   // Sequence
   // ****
   initial begin
      repeat (90000) @(posedge mclk_i);
      failures++;
      report_and_stop();
   end
   initial begin
      mclk_i = 1'b0;
      reset_i = 1'b1;
      {psel, penable, pwrite, paddr, pwdata, lvl} = '0;
      repeat (6) @(posedge mclk_i);
      reset_i <= 1'b0;
      apb(1'b1, IDX_RESULT_HIGH, 8'hff);
      for (int i = 0; i < 3; i++) begin
         apb(1'b0, IDX_CTRL_STATUS + 8'(i), 8'h00);
         chk("reset_value", rd, {24'h0, RESET_BYTE});
      end
      apb(1'b0, 8'h33, 8'h00);
      chk("unmapped", {rd[30:0], err}, 32'h1);
      apb(1'b1, IDX_CTRL_STATUS, 8'h83);
      apb(1'b0, IDX_CTRL_STATUS, 8'h00);
      chk("flag_ro", rd, 32'h03);
      for (int k = 0; k < 4; k++) begin
         dv = 2'(k);
         st = 1'($random(seed));
         ch = 4'($random(seed));
         lvl[ch] = 10'($random(seed));
         apb(1'b1, IDX_MOTOR_CFG, {6'h0, st, 1'b1});
         apb(1'b1, IDX_CTRL_STATUS, {1'b0, dv, 1'b1, ch});
         len = 0;
         while (smp !== 1'b1 && len < 3000) begin
            @(negedge mclk_i);
            len++;
         end
         for (len = 0; smp === 1'b1 && len < 3000; len++) @(negedge mclk_i);
         chk("sample_len", 32'(len), 32'(per(dv) * nsamp(st)));
         ch = ch ^ 4'h9;
         lvl[ch] = k == 0 ? 10'h3ff : k == 1 ? 10'h000 : 10'($random(seed));
         apb(1'b1, IDX_CTRL_STATUS, {1'b0, dv, 1'b1, ch});
         wait_flag();
         chk("irq_on", 32'(irq), 32'h1);
         apb(1'b0, IDX_RESULT_LOW, 8'h00);
         chk("low_bits", rd, {30'h0, lvl[ch][1:0]});
         old = lvl[ch];
         lvl[ch] = ~old;
         // Two full conversion times, so one result lands while locked
         repeat (2 * per(dv) * (nsamp(st) + 11)) @(posedge mclk_i);
         apb(1'b0, IDX_RESULT_HIGH, 8'h00);
         chk("high_locked", rd, {24'h0, old[9:2]});
         apb(1'b0, IDX_CTRL_STATUS, 8'h00);
         chk("flag_clear", 32'(rd[CSR_DONE_BIT]), 32'h0);
         wait_flag();
         apb(1'b0, IDX_RESULT_HIGH, 8'h00);
         chk("high_new", rd, {24'h0, lvl[ch][9:2]});
         apb(1'b1, IDX_POWER_MODE, 8'h01);
         wait_flag();
         repeat (3) @(negedge mclk_i);
         chk("wake", 32'({wake, aon}), 32'h3);
         apb(1'b1, IDX_MOTOR_CFG, {6'h0, st, 1'b0});
         repeat (3) @(negedge mclk_i);
         chk("irq_masked", 32'({irq, wake}), 32'h0);
         apb(1'b1, IDX_POWER_MODE, 8'h02);
         repeat (3) @(negedge mclk_i);
         chk("halt_off", 32'(aon), 32'h0);
         apb(1'b1, IDX_POWER_MODE, 8'h00);
         apb(1'b1, IDX_CTRL_STATUS, {1'b0, dv, 1'b0, ch});
         repeat (3) @(negedge mclk_i);
         chk("disabled", 32'(aon), 32'h0);
         apb(1'b0, IDX_RESULT_HIGH, 8'h00);
         $display("test %0d done", k);
      end
      report_and_stop();
   end
endmodule : tb
